// ==== qlsc_switch_control.sv ====
/*
 * quad lane three port switch control: routing, idle and power-down,
 * loopback, equalizer decode, polarity swap and loss squelch.
 * assumes: pins are asynchronous and synchronised here; the register
 * port is driven from logic on i_core_clk; lane data is asynchronous.
 */
`timescale 1ns/1ns
`default_nettype none
`include "qlsc_defines.svh"

module qlsc_switch_control #(
	parameter int LANES = 4
) (
	// clock, reset, enable
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_clk_en,
	// switch control pins
	input  wire logic [LANES-1:0]     i_lane_select,
	input  wire logic                 i_dual_cast,
	input  wire logic                 i_port_a_loop_enable,
	input  wire logic                 i_port_b_loop_enable,
	input  wire logic                 i_port_c_loop_enable,
	input  wire logic [5:0]           i_equalizer_level_pins,
	input  wire logic [3*LANES-1:0]   i_signal_loss_detect,
	// register port
	input  wire logic [7:0]           i_reg_addr,
	input  wire logic [7:0]           i_reg_wdata,
	input  wire logic                 i_reg_wr,
	input  wire logic                 i_reg_rd,
	output logic      [7:0]           o_reg_rdata,
	// lane data
	input  wire logic [LANES-1:0]     i_port_a_input_lanes,
	input  wire logic [LANES-1:0]     i_port_b_input_lanes,
	input  wire logic [LANES-1:0]     i_port_c_input_lanes,
	output logic      [LANES-1:0]     o_port_a_output_lanes,
	output logic      [LANES-1:0]     o_port_b_output_lanes,
	output logic      [LANES-1:0]     o_port_c_output_lanes,
	// analog controls
	output logic      [6*LANES-1:0]   o_lane_source,
	output logic      [3*LANES-1:0]   o_tx_enable,
	output logic      [3*LANES-1:0]   o_rx_enable,
	output logic      [3*LANES-1:0]   o_rx_swap,
	output logic      [12*LANES-1:0]  o_eq_setting
);
	localparam int NL = 3 * LANES;
	localparam int PW = LANES + 4 + 6 + NL;

	// settings above the top step are held at the top step
	function automatic logic [3:0] eq_clamp(input logic [3:0] v);
		eq_clamp = (v > `QLSC_EQ_MAX) ? `QLSC_EQ_MAX : v;
	endfunction : eq_clamp

	function automatic logic [3:0] eq_pin(input logic [1:0] code);
		case (code)
			2'b00:   eq_pin = `QLSC_EQ_PIN_0;
			2'b01:   eq_pin = `QLSC_EQ_PIN_1;
			2'b10:   eq_pin = `QLSC_EQ_PIN_2;
			default: eq_pin = `QLSC_EQ_PIN_3;
		endcase
	endfunction : eq_pin

	// port index of a register offset (upper two bits), 3 = none
	function automatic logic [1:0] port_of(input logic [7:0] a);
		port_of = a[7:6] - 2'd1;
	endfunction : port_of

	function automatic logic [3:0] lane_data(input qlsc_pkg::qlsc_src_t s,
			input logic a, input logic b, input logic c);
		case (s)
			qlsc_pkg::QLSC_SRC_A: lane_data = {3'h0, a};
			qlsc_pkg::QLSC_SRC_B: lane_data = {3'h0, b};
			qlsc_pkg::QLSC_SRC_C: lane_data = {3'h0, c};
			default:              lane_data = 4'h0;
		endcase
	endfunction : lane_data

	// pin synchronisers: three stages, accept when stages 2 and 3 agree
	logic [PW-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_ff;
	wire  [PW-1:0] pin_raw = {i_signal_loss_detect, i_equalizer_level_pins,
		i_port_c_loop_enable, i_port_b_loop_enable, i_port_a_loop_enable,
		i_dual_cast, i_lane_select};
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
			pin_s3_ff <= '0;
			pin_ff    <= '0;
		end else if (i_clk_en) begin
			pin_s1_ff <= pin_raw;
			pin_s2_ff <= pin_s1_ff;
			pin_s3_ff <= pin_s2_ff;
			pin_ff    <= (pin_s2_ff == pin_s3_ff) ? pin_s3_ff : pin_ff;
		end
	end

	// registers
	logic [7:0]              loop_ff;
	qlsc_pkg::qlsc_mode_t    mode_ff;
	logic [3:0]              eq_all_ff [3];
	logic [7:0]              eq_ln_ff  [3];
	logic [LANES-1:0]        swap_ff   [3];
	logic [3:0]              eq_ff     [NL];

	// address decode
	wire [1:0] wr_port  = port_of(i_reg_addr);
	wire [5:0] wr_low   = i_reg_addr[5:0];
	wire       port_hit = (wr_port != 2'd3);
	wire       hit_all  = port_hit && (wr_low == 6'(`QLSC_OFS_EQ_ALL_A));
	wire       hit_ln   = port_hit && (wr_low == 6'(`QLSC_OFS_EQ_LN_A));
	wire       hit_swap = port_hit && (wr_low == 6'(`QLSC_OFS_SWAP_A));
	wire [3:0] wr_eq    = eq_clamp(i_reg_wdata[`QLSC_EQ_MSB:`QLSC_EQ_LSB]);
	wire [1:0] wr_lane  = i_reg_wdata[`QLSC_LANE_MSB:`QLSC_LANE_LSB];

	// register writes; a port-wide write replaces every lane of that port
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			loop_ff <= `QLSC_RST_BYTE;
			mode_ff <= qlsc_pkg::QLSC_MODE_PIN;
			for (int p = 0; p < 3; p++) begin
				eq_all_ff[p] <= `QLSC_RST_NIB;
				eq_ln_ff[p]  <= `QLSC_RST_BYTE;
				swap_ff[p]   <= '0;
			end
			for (int n = 0; n < NL; n++)
				eq_ff[n] <= `QLSC_RST_NIB;
		end else if (i_clk_en && i_reg_wr) begin
			if (i_reg_addr == `QLSC_OFS_LOOP)
				loop_ff <= i_reg_wdata;
			if (i_reg_addr == `QLSC_OFS_MODE)
				mode_ff <= qlsc_pkg::qlsc_mode_t'(i_reg_wdata[1:0]);
			if (hit_all) begin
				eq_all_ff[wr_port] <= wr_eq;
				for (int l = 0; l < LANES; l++)
					eq_ff[wr_port*LANES+l] <= wr_eq;
			end
			if (hit_ln) begin
				eq_ln_ff[wr_port] <= {2'b00, wr_lane, wr_eq};
				eq_ff[wr_port*LANES+wr_lane] <= wr_eq;
			end
			if (hit_swap)
				swap_ff[wr_port] <= i_reg_wdata[LANES-1:0];
		end
	end

	// read data, one cycle after the strobe; unmapped offsets read zero
	logic [7:0] nxt_rdata;
	always_comb begin
		nxt_rdata = 8'h00;
		if (i_reg_addr == `QLSC_OFS_LOOP)
			nxt_rdata = loop_ff;
		else if (i_reg_addr == `QLSC_OFS_MODE)
			nxt_rdata = {6'h00, mode_ff};
		else if (hit_all)
			nxt_rdata = {4'h0, eq_all_ff[wr_port]};
		else if (hit_ln)
			nxt_rdata = eq_ln_ff[wr_port];
		else if (hit_swap)
			nxt_rdata = {{(8-LANES){1'b0}}, swap_ff[wr_port]};
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_reg_rdata <= 8'h00;
		else if (i_clk_en && i_reg_rd)
			o_reg_rdata <= nxt_rdata;
	end

	// effective controls: routing from registers only in serial mode
	wire             serial  = (mode_ff == qlsc_pkg::QLSC_MODE_SERIAL);
	wire             eq_reg  = serial || (mode_ff == qlsc_pkg::QLSC_MODE_MIXED);
	wire [LANES-1:0] eff_sel = serial ? loop_ff[`QLSC_SEL_MSB:`QLSC_SEL_LSB]
		: pin_ff[LANES-1:0];
	wire             eff_dc  = serial ? loop_ff[`QLSC_DUAL_BIT] : pin_ff[LANES];
	wire             eff_la  = serial ? loop_ff[`QLSC_LOOP_A_BIT] : pin_ff[LANES+1];
	wire             eff_lb  = serial ? loop_ff[`QLSC_LOOP_B_BIT] : pin_ff[LANES+2];
	wire             eff_lc  = serial ? loop_ff[`QLSC_LOOP_C_BIT] : pin_ff[LANES+3];
	wire [5:0]       eq_pins = pin_ff[LANES+9:LANES+4];
	wire [NL-1:0]    loss    = pin_ff[PW-1:LANES+10];

	// per lane routing, power and equalizer decode
	logic [6*LANES-1:0]  nxt_src;
	logic [NL-1:0]       nxt_tx, nxt_rx, nxt_swap;
	logic [12*LANES-1:0] nxt_eq;
	always_comb begin
		qlsc_pkg::qlsc_src_t sa, sb, sc;
		sa = qlsc_pkg::QLSC_SRC_IDLE;
		sb = qlsc_pkg::QLSC_SRC_IDLE;
		sc = qlsc_pkg::QLSC_SRC_IDLE;
		nxt_src  = '0;
		nxt_tx   = '0;
		nxt_rx   = '0;
		nxt_swap = '0;
		nxt_eq   = '0;
		for (int l = 0; l < LANES; l++) begin
			// loopback wins; otherwise demux by select or dual-cast
			sa = eff_la ? qlsc_pkg::QLSC_SRC_A
				: (eff_dc || !eff_sel[l]) ? qlsc_pkg::QLSC_SRC_C
				: qlsc_pkg::QLSC_SRC_IDLE;
			sb = eff_lb ? qlsc_pkg::QLSC_SRC_B
				: (eff_dc || eff_sel[l]) ? qlsc_pkg::QLSC_SRC_C
				: qlsc_pkg::QLSC_SRC_IDLE;
			sc = eff_lc ? qlsc_pkg::QLSC_SRC_C
				: eff_sel[l] ? qlsc_pkg::QLSC_SRC_B : qlsc_pkg::QLSC_SRC_A;
			nxt_src[2*l +: 2]           = sa;
			nxt_src[2*(LANES+l) +: 2]   = sb;
			nxt_src[2*(2*LANES+l) +: 2] = sc;
			// a receiver is on only while some output uses it
			nxt_rx[l]         = (sa == qlsc_pkg::QLSC_SRC_A)
				|| (sc == qlsc_pkg::QLSC_SRC_A);
			nxt_rx[LANES+l]   = (sb == qlsc_pkg::QLSC_SRC_B)
				|| (sc == qlsc_pkg::QLSC_SRC_B);
			nxt_rx[2*LANES+l] = (sa == qlsc_pkg::QLSC_SRC_C)
				|| (sb == qlsc_pkg::QLSC_SRC_C) || (sc == qlsc_pkg::QLSC_SRC_C);
			// idle drive is off; a lost feeding receiver squelches it
			nxt_tx[l] = (sa != qlsc_pkg::QLSC_SRC_IDLE)
				&& !loss[(int'(sa) - 1) * LANES + l];
			nxt_tx[LANES+l] = (sb != qlsc_pkg::QLSC_SRC_IDLE)
				&& !loss[(int'(sb) - 1) * LANES + l];
			nxt_tx[2*LANES+l] = !loss[(int'(sc) - 1) * LANES + l];
		end
		for (int p = 0; p < 3; p++)
			for (int l = 0; l < LANES; l++) begin
				nxt_swap[p*LANES+l] = serial && swap_ff[p][l];
				nxt_eq[4*(p*LANES+l) +: 4] = eq_reg ? eq_ff[p*LANES+l]
					: eq_pin(eq_pins[2*p +: 2]);
			end
	end

	// registered control outputs
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_lane_source <= '0;
			o_tx_enable   <= '0;
			o_rx_enable   <= '0;
			o_rx_swap     <= '0;
			o_eq_setting  <= '0;
		end else if (i_clk_en) begin
			o_lane_source <= nxt_src;
			o_tx_enable   <= nxt_tx;
			o_rx_enable   <= nxt_rx;
			o_rx_swap     <= nxt_swap;
			o_eq_setting  <= nxt_eq;
		end
	end

	// asynchronous data path steered by the registered selects
	wire [LANES-1:0] in_a = i_port_a_input_lanes ^ o_rx_swap[LANES-1:0];
	wire [LANES-1:0] in_b = i_port_b_input_lanes ^ o_rx_swap[2*LANES-1:LANES];
	wire [LANES-1:0] in_c = i_port_c_input_lanes ^ o_rx_swap[NL-1:2*LANES];
	always_comb begin
		logic [3:0] da, db, dc;
		da = 4'h0;
		db = 4'h0;
		dc = 4'h0;
		for (int l = 0; l < LANES; l++) begin
			da = lane_data(qlsc_pkg::qlsc_src_t'(o_lane_source[2*l +: 2]),
				in_a[l], in_b[l], in_c[l]);
			db = lane_data(qlsc_pkg::qlsc_src_t'(o_lane_source[2*(LANES+l) +: 2]),
				in_a[l], in_b[l], in_c[l]);
			dc = lane_data(qlsc_pkg::qlsc_src_t'(o_lane_source[2*(2*LANES+l) +: 2]),
				in_a[l], in_b[l], in_c[l]);
			o_port_a_output_lanes[l] = da[0] && o_tx_enable[l];
			o_port_b_output_lanes[l] = db[0] && o_tx_enable[LANES+l];
			o_port_c_output_lanes[l] = dc[0] && o_tx_enable[2*LANES+l];
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	mux_sel_a_a: assert property (i_clk_en && !eff_lc && !eff_sel[0]
		|=> o_lane_source[2*(2*LANES) +: 2] == qlsc_pkg::QLSC_SRC_A)
		else $error("port c lane 0 not fed from a");
	mux_sel_b_a: assert property (i_clk_en && !eff_lc && eff_sel[0]
		|=> o_lane_source[2*(2*LANES) +: 2] == qlsc_pkg::QLSC_SRC_B)
		else $error("port c lane 0 not fed from b");
	demux_idle_a: assert property (i_clk_en && !eff_dc && !eff_lb && !eff_sel[0]
		|=> o_lane_source[2*LANES +: 2] == qlsc_pkg::QLSC_SRC_IDLE && !o_tx_enable[LANES])
		else $error("unselected port b lane not idle");
	dual_cast_a: assert property (i_clk_en && eff_dc && !eff_la && !eff_lb
		|=> o_lane_source[1:0] == qlsc_pkg::QLSC_SRC_C
		&& o_lane_source[2*LANES +: 2] == qlsc_pkg::QLSC_SRC_C)
		else $error("dual-cast did not feed both ports");
	loop_a_a: assert property (i_clk_en && eff_la
		|=> o_lane_source[1:0] == qlsc_pkg::QLSC_SRC_A)
		else $error("port a loopback ignored");
	loop_c_a: assert property (i_clk_en && eff_lc
		|=> o_lane_source[2*(2*LANES) +: 2] == qlsc_pkg::QLSC_SRC_C)
		else $error("port c loopback ignored");
	rx_power_a: assert property (i_clk_en && !eff_la && !eff_lc && eff_sel[0]
		|=> !o_rx_enable[0])
		else $error("unused receiver left on");
	eq_pin_a: assert property (i_clk_en && !eq_reg && eq_pins[1:0] == 2'b11
		|=> o_eq_setting[3:0] == `QLSC_EQ_PIN_3)
		else $error("pin code 11 not decoded to top step");
	eq_all_a: assert property (i_clk_en && i_reg_wr && i_reg_addr == `QLSC_OFS_EQ_ALL_B
		|=> eq_ff[LANES] == $past(wr_eq) && eq_ff[2*LANES-1] == $past(wr_eq))
		else $error("port write left lanes unequal");
	eq_clamp_a: assert property (eq_ff[0] <= `QLSC_EQ_MAX)
		else $error("equalizer setting above top step");
	squelch_a: assert property (i_clk_en && loss[2*LANES] && !eff_la
		&& (eff_dc || !eff_sel[0]) |=> !o_tx_enable[0])
		else $error("lost receiver did not squelch");
	mode_wr_a: assert property (i_clk_en && i_reg_wr && i_reg_addr == `QLSC_OFS_MODE
		|=> mode_ff == $past(i_reg_wdata[1:0]))
		else $error("mode write lost");

	dual_cast_c: cover property (i_clk_en && eff_dc && !eff_la && !eff_lb);
	loop_all_c:  cover property (i_clk_en && eff_la && eff_lb && eff_lc);
	serial_c:    cover property (i_clk_en && serial ##1 i_reg_wr);
	mixed_eq_c:  cover property (i_clk_en && mode_ff == qlsc_pkg::QLSC_MODE_MIXED);

endmodule : qlsc_switch_control
`default_nettype wire

// ==== qlsc_defines.svh ====
/*
 * constants of the quad lane switch control block: register offsets,
 * field positions, codes and reset values.
 * assumes: included by bare name wherever a constant is needed.
 */
//
// Operation
// - mux carries port a or b to c
// - one select bit per lane, 0=a 1=b
// - demux carries c to a, b or both
// - unselected a/b outputs idle in unicast
// - idle transmitter drive switched off
// - unrouted receivers switched off
// - loopback overrides select and dual-cast
// - serial mode loopback from 0x01 bits 6:4
// - a/b loopback returns own input
// - c loopback returns c input
// - dual-cast sends c to both a and b
// - pin code gives 0/4/8/18 dB
// - register setting 0..9, 2 dB steps
// - port register sets all four lanes
// - per-lane register sets one lane
// - port write overwrites per-lane settings
// - signal loss squelches associated transmitter
// - per-lane receive polarity swap
// - mode field: 00 pin, 10 mixed, 11 serial
// - mixed mode: pins route, registers set eq
`ifndef QLSC_DEFINES_SVH
`define QLSC_DEFINES_SVH

// register offsets
`define QLSC_OFS_LOOP     8'h01
`define QLSC_OFS_MODE     8'h0f
`define QLSC_OFS_EQ_ALL_A 8'h41
`define QLSC_OFS_EQ_LN_A  8'h42
`define QLSC_OFS_SWAP_A   8'h44
`define QLSC_OFS_EQ_ALL_B 8'h81
`define QLSC_OFS_EQ_LN_B  8'h82
`define QLSC_OFS_SWAP_B   8'h84
`define QLSC_OFS_EQ_ALL_C 8'hc1
`define QLSC_OFS_EQ_LN_C  8'hc2
`define QLSC_OFS_SWAP_C   8'hc4

// fields of the loopback/switch register
`define QLSC_SEL_LSB      0
`define QLSC_SEL_MSB      3
`define QLSC_LOOP_A_BIT   4
`define QLSC_LOOP_B_BIT   5
`define QLSC_LOOP_C_BIT   6
`define QLSC_DUAL_BIT     7

// fields of the equalizer registers
`define QLSC_EQ_LSB       0
`define QLSC_EQ_MSB       3
`define QLSC_LANE_LSB     4
`define QLSC_LANE_MSB     5

// values
`define QLSC_EQ_MAX       4'h9
`define QLSC_EQ_PIN_0     4'h0
`define QLSC_EQ_PIN_1     4'h2
`define QLSC_EQ_PIN_2     4'h4
`define QLSC_EQ_PIN_3     4'h9
`define QLSC_RST_BYTE     8'h00
`define QLSC_RST_NIB      4'h0

`endif

// ==== qlsc_pkg.sv ====
/*
 * types of the quad lane switch control block.
 * assumes: compiled before the design module.
 */
package qlsc_pkg;
	// source feeding one output lane
	typedef enum logic [1:0] {
		QLSC_SRC_IDLE = 2'b00,
		QLSC_SRC_A    = 2'b01,
		QLSC_SRC_B    = 2'b10,
		QLSC_SRC_C    = 2'b11
	} qlsc_src_t;

	// control source mode
	typedef enum logic [1:0] {
		QLSC_MODE_PIN    = 2'b00,
		QLSC_MODE_RSVD   = 2'b01,
		QLSC_MODE_MIXED  = 2'b10,
		QLSC_MODE_SERIAL = 2'b11
	} qlsc_mode_t;
endpackage : qlsc_pkg

// ==== qlsc_far_end.sv ====
/*
 * far-side transceivers: lane data that changes every cycle and loss
 * flags for the lanes that the bench silences.
 * assumes: shares the block's clock; the bench drives i_mute.
 */
`timescale 1ns/1ns
`default_nettype none

module qlsc_far_end (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// lanes the bench silences
	input  wire logic [11:0] i_mute,
	// lane data and loss flags towards the block
	output logic      [3:0]  o_lane_a,
	output logic      [3:0]  o_lane_b,
	output logic      [3:0]  o_lane_c,
	output logic      [11:0] o_loss
);
	logic [11:0] pat_ff;

	// the pattern steps every cycle, so a stale route never matches by luck
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pat_ff <= 12'h5a3;
		end else begin
			pat_ff <= pat_ff + 12'h3a7;
		end
	end

	// a silenced lane keeps toggling as noise but is flagged lost
	assign {o_lane_c, o_lane_b, o_lane_a} = pat_ff;
	assign o_loss                         = i_mute;
endmodule : qlsc_far_end

`default_nettype wire

// ==== quad_lane_switch_control_tb.sv ====
/*
 * testbench of the switch control: routing table, eq pins and registers,
 * loss squelch, mixed and serial control.
 * assumes: qlsc_pkg, qlsc_defines.svh and qlsc_far_end compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
`include "qlsc_defines.svh"

module quad_lane_switch_control_tb;
	logic        i_core_clk = 1'b0;
	logic        i_rst_n    = 1'b0;
	logic [3:0]  sel        = 4'h0;
	logic        dual       = 1'b0;
	logic [2:0]  loop       = 3'h0;
	logic [5:0]  eqp        = 6'h00;
	logic [11:0] mute       = 12'h000;
	logic [7:0]  addr       = 8'h00;
	logic [7:0]  wdata      = 8'h00;
	logic        wr         = 1'b0;
	logic        rd         = 1'b0;
	logic        clk_en     = 1'b1;
	logic [11:0] eswp       = 12'h000;
	logic [7:0]  rdata;
	logic [3:0]  ina, inb, inc, outa, outb, outc;
	logic [11:0] loss, txen, rxen, swp;
	logic [23:0] src;
	logic [47:0] eqs;
	logic [3:0]  pm [4] = '{4'h0, 4'h2, 4'h4, 4'h9};
	int          error_cnt = 0;
	int          checked   = 0;

	// 125 MHz core clock
	always #4 i_core_clk = ~i_core_clk;

	qlsc_far_end qlsc_far_end_i (.i_clk(i_core_clk), .i_rst_n(i_rst_n), .i_mute(mute),
		.o_lane_a(ina), .o_lane_b(inb), .o_lane_c(inc), .o_loss(loss));

	qlsc_switch_control qlsc_switch_control_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
		.i_clk_en(clk_en), .i_lane_select(sel), .i_dual_cast(dual),
		.i_port_a_loop_enable(loop[0]), .i_port_b_loop_enable(loop[1]),
		.i_port_c_loop_enable(loop[2]), .i_equalizer_level_pins(eqp),
		.i_signal_loss_detect(loss), .i_reg_addr(addr), .i_reg_wdata(wdata),
		.i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
		.i_port_a_input_lanes(ina), .i_port_b_input_lanes(inb),
		.i_port_c_input_lanes(inc), .o_port_a_output_lanes(outa),
		.o_port_b_output_lanes(outb), .o_port_c_output_lanes(outc),
		.o_lane_source(src), .o_tx_enable(txen), .o_rx_enable(rxen),
		.o_rx_swap(swp), .o_eq_setting(eqs));

	task automatic chk(input logic [55:0] got, input logic [55:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// inputs change 1 ns after the edge, never on it
	task automatic tick(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : tick

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		addr  = a;
		wdata = d;
		wr    = 1'b1;
		tick(1);
		wr = 1'b0;
		// one idle edge so the next call never re-raises the strobe in this step
		tick(1);
	endtask : reg_wr

	task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd   = 1'b1;
		tick(1);
		rd = 1'b0;
		chk(rdata, exp, "read");
		tick(1);
	endtask : reg_chk

	// expected routing, data, drive and receiver power for given controls
	task automatic chk_route(input logic [3:0] s, input logic d, input logic [2:0] lb);
		logic [23:0] es;
		logic [11:0] et, er, eo, ein;
		int          k;
		int          r;
		es  = '0;
		et  = '0;
		er  = '0;
		eo  = '0;
		ein = {inc, inb, ina} ^ eswp; // receivers as the swap registers should turn them
		for (int l = 0; l < 4; l++) begin
			es[2*l +: 2]    = lb[0] ? 2'h1 : (d | !s[l]) ? 2'h3 : 2'h0;
			es[8+2*l +: 2]  = lb[1] ? 2'h2 : (d | s[l]) ? 2'h3 : 2'h0;
			es[16+2*l +: 2] = lb[2] ? 2'h3 : s[l] ? 2'h2 : 2'h1;
		end
		for (int o = 0; o < 12; o++) begin
			k = int'(es[2*o +: 2]);
			if (k != 0) begin
				r     = (k - 1) * 4 + o % 4;
				er[r] = 1'b1;
				et[o] = !mute[r];
				eo[o] = et[o] & ein[r];
			end
		end
		chk(src, es, "source");
		chk({outc, outb, outa}, eo, "lane data");
		chk(txen, et, "tx drive");
		chk(rxen, er, "rx power");
	endtask : chk_route

	// every loopback and dual-cast combination with select all 0 and all 1, plus a split select
	task automatic t_table;
		for (int i = 0; i < 33; i++) begin
			loop = i[4:2];
			dual = i[1];
			sel  = (i == 32) ? 4'h6 : {4{i[0]}};
			tick(6);
			chk_route(sel, dual, loop);
		end
		$display("test table done");
	endtask : t_table

	task automatic t_eq_pins;
		for (int c = 0; c < 4; c++) begin
			eqp = {c[1:0], c[1:0] + 2'h1, c[1:0] + 2'h2};
			tick(6);
			chk(eqs, {{4{pm[eqp[5:4]]}}, {4{pm[eqp[3:2]]}}, {4{pm[eqp[1:0]]}}}, "eq pins");
		end
		$display("test eq pins done");
	endtask : t_eq_pins

	// a lost receiver silences the transmitters it feeds
	task automatic t_squelch;
		sel  = 4'h0;
		dual = 1'b1;
		loop = 3'h0;
		mute = 12'h901;
		tick(6);
		chk_route(sel, dual, loop);
		mute = 12'h000;
		tick(6);
		$display("test squelch done");
	endtask : t_squelch

	task automatic t_mixed;
		reg_wr(`QLSC_OFS_MODE, 8'h02);
		reg_wr(`QLSC_OFS_EQ_ALL_A, 8'h09);
		reg_wr(`QLSC_OFS_EQ_LN_A, 8'h25);
		reg_wr(`QLSC_OFS_EQ_ALL_B, 8'h0c);
		reg_wr(`QLSC_OFS_EQ_ALL_C, 8'h03);
		sel = 4'h9;
		tick(6);
		chk(eqs, 48'h3333_9999_9599, "eq regs");
		chk_route(sel, dual, loop);
		reg_wr(`QLSC_OFS_EQ_ALL_A, 8'h01);
		tick(2);
		chk(eqs[15:0], 16'h1111, "eq overwrite");
		$display("test mixed done");
	endtask : t_mixed

	// pins ignored, loopback and swap from registers
	task automatic t_serial;
		reg_wr(`QLSC_OFS_MODE, 8'h03);
		reg_wr(`QLSC_OFS_LOOP, 8'h70);
		reg_wr(`QLSC_OFS_SWAP_B, 8'h0a);
		reg_wr(8'h33, 8'hff);
		tick(2);
		eswp = 12'h0a0;
		chk_route(4'h0, 1'b0, 3'b111);
		chk(swp, 12'h0a0, "swap");
		reg_chk(`QLSC_OFS_LOOP, 8'h70);
		reg_chk(`QLSC_OFS_MODE, 8'h03);
		reg_chk(8'h33, 8'h00);
		$display("test serial done");
	endtask : t_serial

	// with the enable low a write is dropped and the routing holds
	task automatic t_freeze;
		clk_en = 1'b0;
		reg_wr(`QLSC_OFS_LOOP, 8'h8f);
		tick(2);
		chk_route(4'h0, 1'b0, 3'b111);
		clk_en = 1'b1;
		reg_chk(`QLSC_OFS_LOOP, 8'h70);
		$display("test freeze done");
	endtask : t_freeze

	// reset held for 10 cycles, outputs idle meanwhile, registers at defaults
	task automatic t_reset;
		tick(9);
		chk({src, txen, rxen, rdata}, 56'h0, "reset");
		tick(1);
		i_rst_n = 1'b1;
		reg_chk(`QLSC_OFS_LOOP, 8'h00);
		reg_chk(`QLSC_OFS_MODE, 8'h00);
		$display("test reset done");
	endtask : t_reset

	task automatic summarize;
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	// main sequence
	initial begin
		t_reset();
		t_table();
		t_eq_pins();
		t_squelch();
		t_mixed();
		t_serial();
		t_freeze();
		summarize();
	end

	// watchdog against a hung run
	initial begin
		#200000;
		$display("BAD t=%0t watchdog expired", $time);
		error_cnt++;
		summarize();
	end
endmodule : quad_lane_switch_control_tb

`default_nettype wire
